// ---- verilog/trltd_pkg.sv ----
// package: register map, fields, resets and carriers for the readout block
package trltd_pkg;

    // apb address width and register index width
    localparam int TRLTD_AW = 8;
    localparam int TRLTD_IW = TRLTD_AW - 2;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_FLAGS1 = 6'h00;
    localparam logic [5:0] IDX_FLAGS2 = 6'h01;
    localparam logic [5:0] IDX_LSB_INT_SUP = 6'h03;
    localparam logic [5:0] IDX_LSB_EXT = 6'h04;
    localparam logic [5:0] IDX_MSB_SUP = 6'h06;
    localparam logic [5:0] IDX_MSB_INT = 6'h07;
    localparam logic [5:0] IDX_MSB_EXT = 6'h08;
    localparam logic [5:0] IDX_CFG1 = 6'h18;
    localparam logic [5:0] IDX_CFG3 = 6'h1A;
    localparam logic [5:0] IDX_DAC_SPAN = 6'h1B;
    localparam logic [5:0] IDX_MASK1 = 6'h1D;
    localparam logic [5:0] IDX_MASK2 = 6'h1E;
    localparam logic [5:0] IDX_OFF_INT = 6'h21;
    localparam logic [5:0] IDX_OFF_EXT = 6'h22;
    localparam logic [5:0] IDX_SUP_HIGH = 6'h23;
    localparam logic [5:0] IDX_SUP_LOW = 6'h24;
    localparam logic [5:0] IDX_INT_HIGH = 6'h25;
    localparam logic [5:0] IDX_INT_LOW = 6'h26;
    localparam logic [5:0] IDX_EXT_HIGH = 6'h27;
    localparam logic [5:0] IDX_EXT_LOW = 6'h28;

    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_OFF = 8'hD8;
    localparam logic [7:0] RST_SUP_HIGH = 8'hC9;
    localparam logic [7:0] RST_SUP_LOW = 8'h62;
    localparam logic [7:0] RST_INT_HIGH = 8'h64;
    localparam logic [7:0] RST_INT_LOW = 8'hC9;
    localparam logic [7:0] RST_EXT_HIGH = 8'hFF;
    localparam logic [7:0] RST_EXT_LOW = 8'h00;

    // field positions
    localparam int CFG1_POL_BIT = 1;
    localparam int CFG1_SWRST_BIT = 7;
    localparam int CFG3_RES10_BIT = 1;
    localparam int CFG3_DACA_BIT = 5;
    localparam int CFG3_DACB_BIT = 6;
    localparam int SPAN_A_BIT = 0;
    localparam int SPAN_B_BIT = 1;
    localparam int F1_INT_HIGH = 0;
    localparam int F1_INT_LOW = 1;
    localparam int F1_EXT_HIGH = 2;
    localparam int F1_EXT_LOW = 3;
    localparam int F1_EXT_FAULT = 4;
    localparam int F2_SUPPLY = 4;
    localparam int LSB_INT_POS = 0;
    localparam int LSB_SUP_POS = 2;
    localparam int LSB_EXT_POS = 0;
    localparam int FRAC_BITS = 2;

    // thermal full scale: 8-bit in whole degrees, 10-bit in quarter degrees
    localparam logic [11:0] DAC8_FULL = 12'h0FF;
    localparam logic [11:0] DAC10_FULL = 12'h3FF;

    typedef enum logic [1:0] {
        CH_SUPPLY,
        CH_INTERNAL,
        CH_EXTERNAL
    } trltd_chan_t;

    // one finished conversion from the sequencer
    typedef struct packed {
        logic valid;
        trltd_chan_t chan;
        logic [9:0] value;
    } trltd_meas_t;

    // one thermal dac channel toward the analog dac
    typedef struct packed {
        logic [9:0] code;
        logic update;
        logic span2;
        logic res10;
    } trltd_dac_t;

endpackage

// ---- verilog/trltd_core.sv ----
// readout core: result registers, limits, flags, locks and thermal dacs
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps

// How it works
// [RQ1] one result lsb is a quarter degree
// [RQ2] temperatures are 10-bit two's complement codes
// [RQ3] negative codes read as signed quarter degrees
// [RQ4] store each result, compare with channel limits
// [RQ5] 10-bit results against 8-bit limits
// [RQ6] unmasked out-of-limit events set status flags
// [RQ7] interrupt pin active with programmable polarity
// [RQ8] config3 bits 5,6 select thermal dacs
// [RQ9] thermal dac refreshed on each new result
// [RQ10] 8-bit whole degrees, bit 1 quarter degrees
// [RQ11] dac config bits double dac spans
// [RQ12] track -128 to +127, default zero -40
// [RQ13] offset register sets zero-volt temperature
// [RQ14] host writes offset in two's complement
// [RQ15] clamp at full scale past span top
// [RQ16] code equals temperature minus zero point
// [RQ17] results split into msb and lsb registers
// [RQ18] lsb read freezes its msb registers
// [RQ19] reading a frozen msb releases all
// [RQ20] msb read freezes nothing else
// [RQ21] status registers clear on read, soft reset
// [RQ22] compare upper eight result bits with limit
// [RQ23] interrupt held while unmasked flag remains
module trltd_core
    import trltd_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TRLTD_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // conversion results and sensor fault
    input wire trltd_meas_t meas,
    input wire logic ext_fault,
    // interrupt pin level
    output logic int_out,
    // thermal dac a (internal) and b (external)
    output trltd_dac_t [1:0] dac
);

    logic [TRLTD_IW-1:0] idx;
    logic setup;
    logic acc;
    logic rd;
    logic wr;
    logic err_q;
    logic next_err;
    logic [7:0] next_rdata;

    // writable registers
    logic [7:0] cfg1;
    logic [7:0] cfg3;
    logic [7:0] span_cfg;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] off_int;
    logic [7:0] off_ext;
    logic [7:0] sup_high;
    logic [7:0] sup_low;
    logic [7:0] int_high;
    logic [7:0] int_low;
    logic [7:0] ext_high;
    logic [7:0] ext_low;

    // result registers
    logic [7:0] sup_msb;
    logic [7:0] int_msb;
    logic [7:0] ext_msb;
    logic [1:0] sup_lsb;
    logic [1:0] int_lsb;
    logic [1:0] ext_lsb;
    logic lock_a;
    logic lock_b;

    logic [7:0] flags1;
    logic [7:0] flags2;
    logic [7:0] raw1;
    logic [7:0] raw2;
    logic swrst;
    logic got_sup;
    logic got_int;
    logic got_ext;
    logic [7:0] res_msb;

    assign idx = paddr[TRLTD_AW-1:2];
    assign setup = psel & ~penable;
    assign acc = psel & penable;
    // zero wait states: every access ends in its first access cycle
    assign pready = 1'b1;
    assign rd = acc & ~pwrite & ~err_q;
    assign wr = acc & pwrite & ~err_q;
    assign swrst = cfg1[CFG1_SWRST_BIT];

    assign got_sup = meas.valid & (meas.chan == CH_SUPPLY);
    assign got_int = meas.valid & (meas.chan == CH_INTERNAL);
    assign got_ext = meas.valid & (meas.chan == CH_EXTERNAL);
    assign res_msb = meas.value[9:FRAC_BITS]; // [RQ22]

    // read mux and decode; unmapped or misaligned accesses and writes to
    // read-only registers are answered with an error
    always_comb begin
        next_rdata = 8'h00;
        next_err = 1'b0;
        case (idx)
            IDX_FLAGS1: next_rdata = flags1;
            IDX_FLAGS2: next_rdata = flags2;
            IDX_LSB_INT_SUP: begin
                next_rdata = {4'h0, sup_lsb, int_lsb}; // [RQ17]
            end
            IDX_LSB_EXT: next_rdata = {6'h00, ext_lsb};
            IDX_MSB_SUP: next_rdata = sup_msb;
            IDX_MSB_INT: next_rdata = int_msb;
            IDX_MSB_EXT: next_rdata = ext_msb;
            IDX_CFG1: next_rdata = cfg1;
            IDX_CFG3: next_rdata = cfg3;
            IDX_DAC_SPAN: next_rdata = span_cfg;
            IDX_MASK1: next_rdata = mask1;
            IDX_MASK2: next_rdata = mask2;
            IDX_OFF_INT: next_rdata = off_int;
            IDX_OFF_EXT: next_rdata = off_ext;
            IDX_SUP_HIGH: next_rdata = sup_high;
            IDX_SUP_LOW: next_rdata = sup_low;
            IDX_INT_HIGH: next_rdata = int_high;
            IDX_INT_LOW: next_rdata = int_low;
            IDX_EXT_HIGH: next_rdata = ext_high;
            IDX_EXT_LOW: next_rdata = ext_low;
            default: next_err = 1'b1;
        endcase
        if (pwrite && idx < IDX_CFG1) begin
            next_err = 1'b1;
        end
        if (paddr[1:0] != 2'b00) begin
            next_err = 1'b1;
        end
    end

    // read data and error are captured in the setup cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (ce && setup) begin
            prdata <= pwrite ? 32'h0000_0000 : {24'h000000, next_rdata};
            err_q <= next_err;
        end
    end

    always_comb begin
        pslverr = acc & err_q;
    end

    // configuration and limit registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg1 <= RST_ZERO;
            cfg3 <= RST_ZERO;
            span_cfg <= RST_ZERO;
            mask1 <= RST_ZERO;
            mask2 <= RST_ZERO;
            off_int <= RST_OFF; // [RQ12]
            off_ext <= RST_OFF;
            sup_high <= RST_SUP_HIGH;
            sup_low <= RST_SUP_LOW;
            int_high <= RST_INT_HIGH;
            int_low <= RST_INT_LOW;
            ext_high <= RST_EXT_HIGH;
            ext_low <= RST_EXT_LOW;
        end else if (ce) begin
            // soft reset bit lasts one cycle
            if (swrst) begin
                cfg1[CFG1_SWRST_BIT] <= 1'b0;
            end
            if (wr) begin
                case (idx)
                    IDX_CFG1: cfg1 <= pwdata[7:0];
                    IDX_CFG3: cfg3 <= pwdata[7:0];
                    IDX_DAC_SPAN: span_cfg <= pwdata[7:0];
                    IDX_MASK1: mask1 <= pwdata[7:0];
                    IDX_MASK2: mask2 <= pwdata[7:0];
                    IDX_OFF_INT: off_int <= pwdata[7:0]; // [RQ13] [RQ14]
                    IDX_OFF_EXT: off_ext <= pwdata[7:0];
                    IDX_SUP_HIGH: sup_high <= pwdata[7:0];
                    IDX_SUP_LOW: sup_low <= pwdata[7:0];
                    IDX_INT_HIGH: int_high <= pwdata[7:0];
                    IDX_INT_LOW: int_low <= pwdata[7:0];
                    IDX_EXT_HIGH: ext_high <= pwdata[7:0];
                    IDX_EXT_LOW: ext_low <= pwdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    // msb locks: an lsb read freezes its msbs, any frozen msb read
    // releases them all
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_a <= 1'b0;
            lock_b <= 1'b0;
        end else if (ce && rd) begin
            if ((idx == IDX_MSB_SUP || idx == IDX_MSB_INT) && lock_a
                    || idx == IDX_MSB_EXT && lock_b) begin
                lock_a <= 1'b0; // [RQ19]
                lock_b <= 1'b0; // [RQ19]
            end else if (idx == IDX_LSB_INT_SUP) begin
                lock_a <= 1'b1; // [RQ18] [RQ20]
            end else if (idx == IDX_LSB_EXT) begin
                lock_b <= 1'b1; // [RQ18] [RQ20]
            end
        end
    end

    // result storage; lsbs keep updating, frozen msbs do not
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sup_msb <= RST_ZERO;
            int_msb <= RST_ZERO;
            ext_msb <= RST_ZERO;
            sup_lsb <= 2'b00;
            int_lsb <= 2'b00;
            ext_lsb <= 2'b00;
        end else if (ce) begin
            if (got_sup) begin
                sup_lsb <= meas.value[FRAC_BITS-1:0]; // [RQ4] [RQ17]
                if (!lock_a) begin
                    sup_msb <= res_msb; // [RQ18]
                end
            end
            if (got_int) begin
                int_lsb <= meas.value[FRAC_BITS-1:0]; // [RQ1] [RQ2] [RQ4]
                if (!lock_a) begin
                    int_msb <= res_msb; // [RQ18]
                end
            end
            if (got_ext) begin
                ext_lsb <= meas.value[FRAC_BITS-1:0]; // [RQ4]
                if (!lock_b) begin
                    ext_msb <= res_msb; // [RQ18]
                end
            end
        end
    end

    // limit comparisons on the 8 upper bits; temperatures signed,
    // supply unsigned
    always_comb begin
        raw1 = 8'h00;
        raw2 = 8'h00;
        raw1[F1_INT_HIGH] = got_int
            && $signed(res_msb) > $signed(int_high); // [RQ5] [RQ3]
        raw1[F1_INT_LOW] = got_int
            && $signed(res_msb) < $signed(int_low); // [RQ5] [RQ3]
        raw1[F1_EXT_HIGH] = got_ext
            && $signed(res_msb) > $signed(ext_high); // [RQ5]
        raw1[F1_EXT_LOW] = got_ext
            && $signed(res_msb) < $signed(ext_low); // [RQ5]
        raw1[F1_EXT_FAULT] = ext_fault;
        raw2[F2_SUPPLY] = got_sup
            && (res_msb > sup_high || res_msb < sup_low); // [RQ5] [RQ22]
    end

    // sticky flags: a new event wins over a read or soft-reset clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags1 <= RST_ZERO;
            flags2 <= RST_ZERO;
        end else if (ce) begin
            flags1 <= ((rd && idx == IDX_FLAGS1) || swrst
                ? 8'h00 : flags1) | (raw1 & ~mask1); // [RQ6] [RQ21]
            flags2 <= ((rd && idx == IDX_FLAGS2) || swrst
                ? 8'h00 : flags2) | (raw2 & ~mask2); // [RQ6] [RQ21]
        end
    end

    // masking later also hides a flag already set
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_out <= 1'b0;
        end else if (ce) begin
            int_out <= (|(flags1 & ~mask1) || |(flags2 & ~mask2))
                == cfg1[CFG1_POL_BIT]; // [RQ7] [RQ23]
        end
    end

    // thermal dacs: a follows internal, b follows external
    for (genvar i = 0; i < 2; i++) begin : g_dac
        logic sel;
        logic hit;
        logic [7:0] offs;
        logic [11:0] t12;
        logic [11:0] diff10;
        logic [11:0] diff8;
        logic [9:0] next_code;

        assign sel = (i == 0) ? cfg3[CFG3_DACA_BIT] : cfg3[CFG3_DACB_BIT];
        assign hit = (i == 0) ? got_int : got_ext;
        assign offs = (i == 0) ? off_int : off_ext;
        assign t12 = {{2{meas.value[9]}}, meas.value};
        // offset is whole degrees, scaled up for quarter-degree mode
        assign diff10 = t12 - {{2{offs[7]}}, offs, 2'b00}; // [RQ16]
        assign diff8 = {{4{meas.value[9]}}, res_msb}
            - {{4{offs[7]}}, offs}; // [RQ16]

        // below zero point sits at zero, past span top at full scale
        always_comb begin
            if (cfg3[CFG3_RES10_BIT]) begin
                if (diff10[11]) begin
                    next_code = 10'h000;
                end else if (diff10 > DAC10_FULL) begin
                    next_code = 10'h3FF; // [RQ15]
                end else begin
                    next_code = diff10[9:0]; // [RQ10]
                end
            end else begin
                if (diff8[11]) begin
                    next_code = 10'h000;
                end else if (diff8 > DAC8_FULL) begin
                    next_code = {DAC8_FULL[7:0], 2'b00}; // [RQ15]
                end else begin
                    next_code = {diff8[7:0], 2'b00}; // [RQ10]
                end
            end
        end

        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                dac[i] <= '0;
            end else if (ce) begin
                dac[i].update <= sel & hit; // [RQ9]
                dac[i].span2 <= span_cfg[i == 0 ? SPAN_A_BIT
                    : SPAN_B_BIT]; // [RQ11]
                dac[i].res10 <= cfg3[CFG3_RES10_BIT];
                if (sel && hit) begin
                    dac[i].code <= next_code; // [RQ8] [RQ9]
                end
            end
        end
    end

endmodule // trltd_core

// ---- tb/trltd_core_properties.sv ----
// checker: apb, interrupt and thermal dac properties of the readout core
`timescale 1ns/10ps
module trltd_core_properties
    import trltd_pkg::*;
(
    // clock, reset and enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TRLTD_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // results and outputs
    input wire trltd_meas_t meas,
    input wire logic ext_fault,
    input wire logic int_out,
    input wire trltd_dac_t [1:0] dac
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic pol;
    logic mask_fault;
    logic wr_acc;
    assign wr_acc = psel && penable && pwrite && !pslverr;
    // mirror of polarity and fault mask, seen from host writes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pol <= 1'b0;
            mask_fault <= 1'b0;
        end else if (wr_acc && paddr[7:2] == IDX_CFG1) begin
            pol <= pwdata[CFG1_POL_BIT];
        end else if (wr_acc && paddr[7:2] == IDX_MASK1) begin
            mask_fault <= pwdata[F1_EXT_FAULT];
        end
    end
    AST_PREADY: assert property (psel && penable |-> pready)
        else $error("no ready in access phase");
    AST_RO_WRITE: assert property (psel && penable && pwrite
        && paddr[7:2] < IDX_CFG1 |-> pslverr)
        else $error("write to read-only place accepted");
    AST_MISALIGN: assert property (psel && penable
        && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access accepted");
    AST_READ_UPPER: assert property (psel && penable && !pwrite
        |-> prdata[31:8] == 24'h0)
        else $error("read data above byte not zero");
    AST_UPD_A: assert property (dac[0].update
        |-> $past(meas.valid && ce && meas.chan == CH_INTERNAL))
        else $error("dac a updated without internal result");
    AST_UPD_B: assert property (dac[1].update
        |-> $past(meas.valid && ce && meas.chan == CH_EXTERNAL))
        else $error("dac b updated without external result");
    AST_HOLD_A: assert property (!dac[0].update
        |-> $stable(dac[0].code))
        else $error("dac a code moved without update");
    AST_RES8: assert property (dac[0].update && !dac[0].res10
        |-> dac[0].code[1:0] == 2'b00)
        else $error("8-bit code has quarter bits");
    AST_FAULT_INT: assert property (ext_fault && ce && !mask_fault
        ##1 ce && !wr_acc |=> int_out == pol)
        else $error("fault did not drive interrupt");
endmodule // trltd_core_properties

bind trltd_core trltd_core_properties u_props (.ref_clk(ref_clk),
    .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas(meas),
    .ext_fault(ext_fault), .int_out(int_out), .dac(dac));

// ---- tb/trltd_host.sv ----
// host model: apb master that reaches the readout registers
`timescale 1ns/10ps
module trltd_host
    import trltd_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [TRLTD_AW-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    // wait for ready ran out
    output logic tmo
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        tmo = 1'b0;
    end
    // an idle edge first, so back-to-back calls never drive twice at once
    task automatic xfer(input logic w, input logic [TRLTD_AW-1:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 64) begin
            n++;
            @(posedge ref_clk);
        end
        if (n == 64) tmo <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // trltd_host

// ---- tb/trltd_core_bench.sv ----
// bench: registers, locks, limits, interrupt and thermal dacs
`timescale 1ns/10ps
module trltd_core_bench
    import trltd_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, int_out, tmo;
    logic [TRLTD_AW-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic ext_fault = 1'b0;
    logic ce = 1'b1;
    trltd_meas_t meas = '0;
    trltd_dac_t [1:0] dac;
    logic [32:0] qr[$];
    logic [10:0] qd[$];
    logic [9:0] v;
    int n_errors = 0;
    int checked = 0;
    always #20 ref_clk = ~ref_clk;
    // ce dropped once: a result that arrives while frozen must be lost
    trltd_core DUT (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .meas(meas), .ext_fault(ext_fault),
        .int_out(int_out), .dac(dac));
    trltd_host host (.ref_clk(ref_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .tmo(tmo));
    function automatic logic [9:0] tcode(logic [9:0] c, logic [7:0] off,
        logic r10);
        int t;
        t = r10 ? $signed(c) - 4 * $signed(off)
            : ($signed(c[9:2]) - $signed(off)) * 4;
        if (t < 0) t = 0;
        if (t > (r10 ? 1023 : 1020)) t = r10 ? 1023 : 1020;
        return t[9:0];
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [5:0] i, input logic [7:0] e);
        qr.push_back({9'h0, 16'h0, e});
        host.xfer(1'b0, {i, 2'b00}, 32'h0);
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        qr.push_back(33'h0);
        host.xfer(1'b1, {i, 2'b00}, {24'h0, d});
    endtask
    task automatic bad(input logic w, input logic [7:0] a);
        qr.push_back({1'b1, 32'h0});
        host.xfer(w, a, 32'h0);
    endtask
    task automatic put(input trltd_chan_t c, input logic [9:0] val);
        @(posedge ref_clk);
        meas <= '{1'b1, c, val};
        @(posedge ref_clk);
        meas.valid <= 1'b0;
    endtask
    task automatic results;
        // a note never matched means an answer or update went missing
        if (qr.size() != 0 || qd.size() != 0) n_errors++;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // watcher: oldest note against each answer and each dac update
    always @(posedge ref_clk) begin
        logic [32:0] n;
        logic [10:0] d;
        if ((psel && penable && pready) === 1'b1) begin
            n = qr.pop_front();
            chk(pslverr, n[32]);
            if (!pwrite && !n[32]) chk(prdata, n[31:0]);
        end
        for (int i = 0; i < 2; i++) begin
            if (dac[i].update === 1'b1) begin
                d = qd.pop_front();
                chk({i[0], dac[i].code}, d);
            end
        end
    end
    always @(posedge tmo) begin
        n_errors++;
        results();
    end
    initial begin
        v = 10'($urandom(86));
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(IDX_FLAGS1, RST_ZERO);
        rd(IDX_OFF_INT, RST_OFF);
        rd(IDX_INT_HIGH, RST_INT_HIGH);
        bad(1'b1, {IDX_MSB_INT, 2'b00});
        bad(1'b0, 8'h08);
        bad(1'b0, 8'h85);
        rd(IDX_MSB_INT, RST_ZERO);
        wr(IDX_CFG3, 8'h62);
        v = 10'($urandom_range(0, 399));
        qd.push_back({1'b0, tcode(v, 8'hD8, 1'b1)});
        put(CH_INTERNAL, v);
        rd(IDX_LSB_INT_SUP, {6'h0, v[1:0]});
        qd.push_back({1'b0, tcode(10'h3A0, 8'hD8, 1'b1)});
        put(CH_INTERNAL, 10'h3A0);
        rd(IDX_MSB_INT, v[9:2]);
        qd.push_back({1'b0, tcode(10'h3A4, 8'hD8, 1'b1)});
        put(CH_INTERNAL, 10'h3A4);
        rd(IDX_MSB_INT, 8'hE9);
        qd.push_back({1'b0, tcode(10'h3A5, 8'hD8, 1'b1)});
        put(CH_INTERNAL, 10'h3A5);
        rd(IDX_LSB_INT_SUP, 8'h01);
        rd(IDX_MSB_SUP, RST_ZERO);
        // offset -128 written as -128 + 0, top bit set and lower bits zero
        wr(IDX_OFF_INT, 8'h80);
        qd.push_back({1'b0, 10'h3FF});
        put(CH_INTERNAL, 10'h1FF);
        @(posedge ref_clk);
        #1 chk(int_out, 1'b0);
        rd(IDX_FLAGS1, 8'h01);
        rd(IDX_FLAGS1, 8'h00);
        @(posedge ref_clk);
        #1 chk(int_out, 1'b1);
        wr(IDX_CFG3, 8'h60);
        wr(IDX_OFF_INT, 8'h0A);
        wr(IDX_MASK1, 8'h01);
        qd.push_back({1'b0, 10'h000});
        put(CH_INTERNAL, 10'h000);
        qd.push_back({1'b0, tcode(10'h1FF, 8'h0A, 1'b0)});
        put(CH_INTERNAL, 10'h1FF);
        rd(IDX_FLAGS1, 8'h00);
        wr(IDX_MASK1, 8'h00);
        wr(IDX_CFG1, 8'h02);
        wr(IDX_DAC_SPAN, 8'h03);
        @(posedge ref_clk);
        #1 chk(int_out, 1'b0);
        @(posedge ref_clk) ext_fault <= 1'b1;
        @(posedge ref_clk) ext_fault <= 1'b0;
        @(posedge ref_clk);
        #1 chk(int_out, 1'b1);
        rd(IDX_FLAGS1, 8'h10);
        qd.push_back({1'b1, tcode(10'h064, 8'hD8, 1'b0)});
        put(CH_EXTERNAL, 10'h064);
        #1 chk(dac[1].span2, 1'b1);
        put(CH_SUPPLY, 10'h3FF);
        rd(IDX_FLAGS2, 8'h10);
        // supply result below its low limit, offered while frozen
        ce <= 1'b0;
        put(CH_SUPPLY, 10'h000);
        ce <= 1'b1;
        rd(IDX_FLAGS2, 8'h00);
        rd(IDX_MSB_SUP, 8'hFF);
        rd(IDX_LSB_INT_SUP, 8'h0F);
        // external high flag from the last external result still pends
        #1 chk(int_out, 1'b1);
        wr(IDX_CFG1, 8'h82);
        rd(IDX_FLAGS1, 8'h00);
        rd(IDX_CFG1, 8'h02);
        @(posedge ref_clk);
        #1 chk(int_out, 1'b0);
        results();
    end
endmodule // trltd_core_bench
